// ### mct_backoff.sv
// One backoff engine for a single access category.
// Assumes slot ticks and the idle qualifier come from the same clock.
`timescale 1ns/1ps
module mct_backoff #(
  parameter int BW = mct_pkg::BO_W
) (
  input  wire logic          core_clk_i,
  input  wire logic          resetn_i,
  input  wire logic          load_i,
  input  wire logic [BW-1:0] load_val_i,
  input  wire logic          slot_tick_i,
  input  wire logic          idle_i,
  input  wire logic          grant_i,
  output logic               pend_o,
  output logic [BW-1:0]      cnt_o
);
  import mct_pkg::*;

  logic          active_r;
  logic [BW-1:0] cnt_r;
  logic          step;

  ////////////////////////////////////////////////////////////////////////
  // A slot only counts when it ended on an idle medium; otherwise hold.
  assign step = slot_tick_i && idle_i && active_r && (cnt_r != '0);

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      cnt_r <= '0;
    else if (load_i)
      cnt_r <= load_val_i;
    else if (step)
      cnt_r <= cnt_r - 1'b1;
  end

  // A reload in the grant cycle wins, so a new backoff is never dropped.
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      active_r <= 1'b0;
    else if (load_i)
      active_r <= 1'b1;
    else if (grant_i)
      active_r <= 1'b0;
  end

  assign pend_o = active_r && (cnt_r == '0);
  assign cnt_o  = cnt_r;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  chk_bo_hold: assert property (!idle_i && !load_i |=> cnt_o == $past(cnt_o))
    else $error("backoff moved on a busy medium");
  chk_bo_step: assert property (step && !load_i |=> cnt_o == $past(cnt_o) - 1'b1)
    else $error("backoff missed a slot decrement");
endmodule

// ### mct_nav.sv
// Virtual carrier-sense timer fed by received duration fields.
// Assumes a one-cycle microsecond tick from the same clock.
`timescale 1ns/1ps
module mct_nav #(
  parameter int NW = mct_pkg::NAV_W
) (
  input  wire logic          core_clk_i,
  input  wire logic          resetn_i,
  input  wire logic          tick_i,
  input  wire logic          upd_i,
  input  wire logic [NW-1:0] dur_i,
  input  wire logic          clr_i,
  output logic               busy_o
);
  import mct_pkg::*;

  logic [NW-1:0] nav_r;
  logic          take;

  ////////////////////////////////////////////////////////////////////////
  // Only a longer reservation replaces the running one.
  assign take = upd_i && (dur_i > nav_r);

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      nav_r <= NAV_RST;
    else if (clr_i)
      nav_r <= NAV_RST;
    else if (take)
      nav_r <= dur_i;
    else if (tick_i && nav_r != '0)
      nav_r <= nav_r - 1'b1;
  end

  assign busy_o = (nav_r != '0);

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  chk_nav_max: assert property (take && !clr_i |=> nav_r == $past(dur_i))
    else $error("longer duration not adopted");
  chk_nav_keep: assert property (upd_i && !take && !tick_i && !clr_i |=> $stable(nav_r))
    else $error("shorter duration replaced NAV");
endmodule

// ### mct_phy_model.sv
// PHY end of the programming port: acks each access after a set wait.
// Assumes the unit holds its request until the ack edge.
`timescale 1ns/1ps
module mct_phy_model (
  input  wire logic                  core_clk_i,
  input  wire logic                  resetn_i,
  input  wire logic [3:0]            dly_i,
  input  wire logic                  vld_i,
  input  wire mct_pkg::mct_phy_req_t req_i,
  output logic                       ack_o,
  output logic [15:0]                rdata_o
);
  import mct_pkg::*;
  logic [3:0] wait_r;
  //////////////////////////////////////////
  // Read data toggles outside the ack so a stale sample never matches.
  always_ff @(posedge core_clk_i)
  begin
    ack_o   <= 1'b0;
    rdata_o <= ~rdata_o;
    wait_r  <= (vld_i && !ack_o) ? wait_r + 4'h1 : 4'h0;
    if (!resetn_i)
    begin
      wait_r  <= 4'h0;
      rdata_o <= 16'h0;
    end
    else if (vld_i && !ack_o && wait_r >= dly_i)
    begin
      ack_o   <= 1'b1;
      rdata_o <= {8'ha5, req_i.addr};
    end
  end
endmodule

// ### mct_pkg.sv
// Shared constants and types of the MAC channel-timing unit.
// Assumes a single 50 MHz MAC clock; all but the slow sleep clock is derived from it.
package mct_pkg;

  // Clock period and the microsecond tick derived from it (rounded up).
  localparam int CLK_PERIOD_NS = 20;
  localparam int US_NS         = 1000;
  localparam int US_CYC        = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int US_CW         = $clog2(US_CYC);
  localparam logic [US_CW-1:0] US_LAST = US_CW'(US_CYC - 1);

  // Default sizes of the unit.
  localparam int NUM_AC   = 4;
  localparam int AC_IW    = $clog2(NUM_AC);
  localparam int BO_W     = 10;
  localparam int NAV_W    = 16;
  localparam int TSF_W    = 64;
  localparam int SLP_W    = 32;
  localparam int NUM_TRIG = 2;

  // Reset values and defaults.
  localparam logic [TSF_W-1:0] TSF_RST          = 64'h0;
  localparam logic [NAV_W-1:0] NAV_RST          = 16'h0;
  localparam logic [7:0]       IDLE_US_MAX      = 8'hff;
  localparam logic [7:0]       SLOW_TICK_US_DEF = 8'h1f;

  // Backoff collision policy encodings.
  localparam logic ARB_FIXED = 1'b0;
  localparam logic ARB_RR    = 1'b1;

  // Timing setup given by the microcode controller.
  typedef struct packed {
    logic       arb_pol;
    logic [7:0] sifs_us;
    logic [7:0] rifs_us;
    logic [7:0] ifs_us;
    logic [7:0] slot_us;
  } mct_cfg_t;

  // One access on the PHY programming port.
  typedef struct packed {
    logic        we;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } mct_phy_req_t;

  // Power-save sequencer states.
  typedef enum logic [2:0] {
    SLP_AWAKE = 3'b001,
    SLP_SLEEP = 3'b010,
    SLP_WAKE  = 3'b100
  } mct_slp_st_t;

endpackage

// ### mct_top.sv
// Channel-access and timing unit of the MAC: interframe timers, backoff
// engines, NAV, TSF/TBTT, offset triggers, sleep timer and PHY port mux.
// Assumes microcode and transmit engine share core_clk_i; the PHY busy
// line and the slow sleep clock arrive asynchronously.
//
// Overview of operation
// - Interframe timers start when PHY activity ends.
// - Timed start triggers for responses and bursts.
// - Per-category backoff counts or holds each slot.
// - Zero backoff notifies the transmit engine.
// - Simultaneous zeros resolved by configured policy.
// - Power save stops the MAC clock.
// - Loaded slow-clock sleep timer sets sleep length.
// - Timer expiry restarts clock and restores MAC.
// - TSF advanced by elapsed sleep time.
// - TSF loadable from received beacon timestamps.
// - Target beacon time tracked beside TSF.
// - Triggers fire at programmed TSF offsets.
// - NAV updated from received duration fields.
// - Nonzero NAV makes the medium busy.
// - PHY programming accepted from host or microcode.
`timescale 1ns/1ps
module mct_top #(
  parameter logic [7:0] SLOW_TICK_US = mct_pkg::SLOW_TICK_US_DEF
) (
  input  wire logic                                           core_clk_i,
  input  wire logic                                           resetn_i,
  input  wire mct_pkg::mct_cfg_t                              cfg_i,
  input  wire logic                                           phy_busy_i,
  input  wire logic [mct_pkg::NUM_AC-1:0]                     bo_load_i,
  input  wire logic [mct_pkg::BO_W-1:0]                       bo_val_i,
  output logic                                                txop_grant_o,
  output logic [mct_pkg::AC_IW-1:0]                           txop_ac_o,
  output logic                                                sifs_trig_o,
  output logic                                                rifs_trig_o,
  input  wire logic                                           nav_upd_i,
  input  wire logic [mct_pkg::NAV_W-1:0]                      nav_dur_i,
  input  wire logic                                           nav_clr_i,
  output logic                                                nav_busy_o,
  input  wire logic                                           sleep_req_i,
  input  wire logic [mct_pkg::SLP_W-1:0]                      sleep_cnt_i,
  input  wire logic                                           slow_clk_i,
  output logic                                                mac_clk_en_o,
  output logic                                                wake_o,
  input  wire logic                                           tsf_load_i,
  input  wire logic [mct_pkg::TSF_W-1:0]                      tsf_val_i,
  output logic [mct_pkg::TSF_W-1:0]                           tsf_o,
  input  wire logic                                           tbtt_set_i,
  input  wire logic [mct_pkg::TSF_W-1:0]                      tbtt_val_i,
  input  wire logic [31:0]                                    bcn_intvl_i,
  output logic                                                tbtt_o,
  input  wire logic [mct_pkg::NUM_TRIG-1:0]                   trig_arm_i,
  input  wire logic [mct_pkg::NUM_TRIG-1:0][mct_pkg::TSF_W-1:0] trig_time_i,
  output logic [mct_pkg::NUM_TRIG-1:0]                        trig_o,
  input  wire logic                                           host_req_i,
  input  wire mct_pkg::mct_phy_req_t                          host_req_data_i,
  input  wire logic                                           mc_req_i,
  input  wire mct_pkg::mct_phy_req_t                          mc_req_data_i,
  output logic                                                phy_req_vld_o,
  output mct_pkg::mct_phy_req_t                               phy_req_o,
  input  wire logic                                           phy_ack_i,
  input  wire logic [15:0]                                    phy_rdata_i,
  output logic                                                host_done_o,
  output logic                                                mc_done_o,
  output logic [15:0]                                         prog_rdata_o
);
  import mct_pkg::*;

  // Saturating microsecond count for the idle-time counters.
  function automatic logic [7:0] inc_sat(input logic [7:0] v);
    inc_sat = (v == IDLE_US_MAX) ? v : v + 8'h01;
  endfunction

  // Picks the winning category among those at zero.
  function automatic logic [AC_IW-1:0] pick(input logic [NUM_AC-1:0] p,
                                            input logic pol,
                                            input logic [AC_IW-1:0] last);
    logic [AC_IW-1:0] idx;
    logic [AC_IW-1:0] r;
    r = '0;
    for (int k = NUM_AC - 1; k >= 0; k--)
    begin
      idx = (pol == ARB_RR) ? AC_IW'(last + AC_IW'(k + 1)) : AC_IW'(NUM_AC - 1 - k);
      if (p[idx])
        r = idx;
    end
    pick = r;
  endfunction

  logic                   cca_meta_r;
  logic                   phy_busy_s;
  logic                   slow_meta_r;
  logic                   slow_sync_r;
  logic                   slow_prev_r;
  logic                   slow_rise;
  logic [US_CW-1:0]       us_cnt_r;
  logic                   awake;
  logic                   tick;
  logic                   nav_busy;
  logic                   med_busy;
  logic [7:0]             phy_idle_r;
  logic [7:0]             med_idle_r;
  logic [7:0]             slot_r;
  logic                   ifs_done;
  logic                   slot_tick;
  logic [NUM_AC-1:0]      bo_pend;
  logic [NUM_AC-1:0]      bo_grant;
  logic                   win_vld;
  logic [AC_IW-1:0]       win_idx;
  logic [AC_IW-1:0]       last_r;
  mct_slp_st_t            slp_st_r;
  logic [SLP_W-1:0]       slp_cnt_r;
  logic [SLP_W-1:0]       slp_el_r;
  logic [TSF_W-1:0]       tsf_r;
  logic [TSF_W-1:0]       adv;
  logic [TSF_W-1:0]       tbtt_r;
  logic                   tbtt_arm_r;
  logic                   pg_busy_r;
  logic                   pg_host_r;
  logic                   pg_take;

  ////////////////////////////////////////////////////////////////////////
  // Two flops on each asynchronous input before any logic looks at it.
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      cca_meta_r  <= 1'b0;
      phy_busy_s  <= 1'b0;
      slow_meta_r <= 1'b0;
      slow_sync_r <= 1'b0;
      slow_prev_r <= 1'b0;
    end
    else
    begin
      cca_meta_r  <= phy_busy_i;
      phy_busy_s  <= cca_meta_r;
      slow_meta_r <= slow_clk_i;
      slow_sync_r <= slow_meta_r;
      slow_prev_r <= slow_sync_r;
    end
  end
  assign slow_rise = slow_sync_r && !slow_prev_r;

  // Microsecond tick. It is withheld while asleep, so timers freeze with
  // the gated MAC clock and TSF is corrected in one step on wake-up.
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i || us_cnt_r == US_LAST)
      us_cnt_r <= '0;
    else
      us_cnt_r <= us_cnt_r + 1'b1;
  end
  assign awake = (slp_st_r == SLP_AWAKE);
  assign tick  = awake && (us_cnt_r == US_LAST);

  ////////////////////////////////////////////////////////////////////////
  // Interframe timers: physical idle for responses, combined for access.
  assign med_busy = phy_busy_s || nav_busy;

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i || phy_busy_s)
      phy_idle_r <= 8'h00;
    else if (tick)
      phy_idle_r <= inc_sat(phy_idle_r);
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i || med_busy)
      med_idle_r <= 8'h00;
    else if (tick)
      med_idle_r <= inc_sat(med_idle_r);
  end

  // Each start trigger fires once, in the microsecond the gap completes.
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      sifs_trig_o <= 1'b0;
      rifs_trig_o <= 1'b0;
    end
    else
    begin
      sifs_trig_o <= tick && !phy_busy_s && phy_idle_r != cfg_i.sifs_us
                     && inc_sat(phy_idle_r) == cfg_i.sifs_us;
      rifs_trig_o <= tick && !phy_busy_s && phy_idle_r != cfg_i.rifs_us
                     && inc_sat(phy_idle_r) == cfg_i.rifs_us;
    end
  end

  // Slot clock starts only after the access gap, restarts on any busy.
  assign ifs_done = !med_busy && (med_idle_r >= cfg_i.ifs_us);

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i || !ifs_done)
      slot_r <= 8'h00;
    else if (tick)
      slot_r <= slot_tick ? 8'h00 : slot_r + 8'h01;
  end
  assign slot_tick = ifs_done && tick && (slot_r == cfg_i.slot_us - 8'h01);

  ////////////////////////////////////////////////////////////////////////
  // Backoff engines, one per access category.
  for (genvar g = 0; g < NUM_AC; g++)
  begin : g_bo
    mct_backoff #(.BW(BO_W)) u_bo (
      .core_clk_i  (core_clk_i),
      .resetn_i    (resetn_i),
      .load_i      (bo_load_i[g]),
      .load_val_i  (bo_val_i),
      .slot_tick_i (slot_tick),
      .idle_i      (ifs_done),
      .grant_i     (bo_grant[g]),
      .pend_o      (bo_pend[g]),
      .cnt_o       ()
    );
  end

  // One winner per cycle; losers stay pending and win in later cycles.
  assign win_vld  = awake && ifs_done && (bo_pend != '0);
  assign win_idx  = pick(bo_pend, cfg_i.arb_pol, last_r);
  assign bo_grant = win_vld ? (NUM_AC'(1) << win_idx) : '0;

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      txop_grant_o <= 1'b0;
      txop_ac_o    <= '0;
      last_r       <= '0;
    end
    else
    begin
      txop_grant_o <= win_vld;
      if (win_vld)
      begin
        txop_ac_o <= win_idx;
        last_r    <= win_idx;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Virtual carrier sense.
  mct_nav #(.NW(NAV_W)) u_nav (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .tick_i     (tick),
    .upd_i      (nav_upd_i),
    .dur_i      (nav_dur_i),
    .clr_i      (nav_clr_i),
    .busy_o     (nav_busy)
  );
  assign nav_busy_o = nav_busy;

  ////////////////////////////////////////////////////////////////////////
  // Power-save sequencer.
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      slp_st_r <= SLP_AWAKE;
    else
      unique case (slp_st_r)
        SLP_AWAKE: if (sleep_req_i) slp_st_r <= SLP_SLEEP;
        SLP_SLEEP: if (slp_cnt_r == '0) slp_st_r <= SLP_WAKE;
        SLP_WAKE:  slp_st_r <= SLP_AWAKE;
      endcase
  end

  // Sleep length counts slow-clock edges; elapsed edges feed the TSF fix.
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      slp_cnt_r <= '0;
      slp_el_r  <= '0;
    end
    else if (awake && sleep_req_i)
    begin
      slp_cnt_r <= sleep_cnt_i;
      slp_el_r  <= '0;
    end
    else if (slp_st_r == SLP_SLEEP && slow_rise && slp_cnt_r != '0)
    begin
      slp_cnt_r <= slp_cnt_r - 1'b1;
      slp_el_r  <= slp_el_r + 1'b1;
    end
  end

  assign mac_clk_en_o = (slp_st_r != SLP_SLEEP);
  assign wake_o       = (slp_st_r == SLP_WAKE);
  assign adv          = {32'h0, slp_el_r} * {56'h0, SLOW_TICK_US};

  ////////////////////////////////////////////////////////////////////////
  // TSF: beacon load first, then sleep correction, then normal count.
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      tsf_r <= TSF_RST;
    else if (tsf_load_i)
      tsf_r <= tsf_val_i;
    else if (wake_o)
      tsf_r <= tsf_r + adv;
    else if (tick)
      tsf_r <= tsf_r + 1'b1;
  end
  assign tsf_o = tsf_r;

  // Target beacon time walks forward one interval per beacon.
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      tbtt_r     <= TSF_RST;
      tbtt_arm_r <= 1'b0;
      tbtt_o     <= 1'b0;
    end
    else
    begin
      tbtt_o <= 1'b0;
      if (tbtt_set_i)
      begin
        tbtt_r     <= tbtt_val_i;
        tbtt_arm_r <= 1'b1;
      end
      else if (awake && tbtt_arm_r && tsf_r >= tbtt_r)
      begin
        tbtt_o     <= 1'b1;
        tbtt_r     <= tbtt_r + {32'h0, bcn_intvl_i};
        tbtt_arm_r <= (bcn_intvl_i != 32'h0);
      end
    end
  end

  // Single-shot triggers at programmed TSF values, such as PSMP slots.
  for (genvar t = 0; t < NUM_TRIG; t++)
  begin : g_trig
    logic             arm_r;
    logic [TSF_W-1:0] time_r;
    always_ff @(posedge core_clk_i)
    begin
      if (!resetn_i)
      begin
        arm_r     <= 1'b0;
        time_r    <= TSF_RST;
        trig_o[t] <= 1'b0;
      end
      else
      begin
        trig_o[t] <= 1'b0;
        if (trig_arm_i[t])
        begin
          arm_r  <= 1'b1;
          time_r <= trig_time_i[t];
        end
        else if (arm_r && awake && tsf_r >= time_r)
        begin
          arm_r     <= 1'b0;
          trig_o[t] <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // PHY programming port: microcode wins ties; one access in flight.
  assign pg_take = !pg_busy_r && !host_done_o && !mc_done_o && (host_req_i || mc_req_i);

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      pg_busy_r    <= 1'b0;
      pg_host_r    <= 1'b0;
      phy_req_o    <= '0;
      host_done_o  <= 1'b0;
      mc_done_o    <= 1'b0;
      prog_rdata_o <= 16'h0000;
    end
    else
    begin
      host_done_o <= pg_busy_r && phy_ack_i && pg_host_r;
      mc_done_o   <= pg_busy_r && phy_ack_i && !pg_host_r;
      if (pg_take)
      begin
        pg_busy_r <= 1'b1;
        pg_host_r <= !mc_req_i;
        phy_req_o <= mc_req_i ? mc_req_data_i : host_req_data_i;
      end
      else if (pg_busy_r && phy_ack_i)
      begin
        pg_busy_r    <= 1'b0;
        prog_rdata_o <= phy_rdata_i;
      end
    end
  end
  assign phy_req_vld_o = pg_busy_r;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  chk_ifs_restart: assert property (phy_busy_s |=> phy_idle_r == 8'h00)
    else $error("interframe timer not restarted by activity");
  chk_sifs_time: assert property (sifs_trig_o |-> phy_idle_r == cfg_i.sifs_us)
    else $error("short gap trigger at wrong time");
  chk_grant_cause: assert property (txop_grant_o |-> $past(bo_pend) != '0)
    else $error("grant without a zero backoff");
  chk_grant_prio: assert property (win_vld && cfg_i.arb_pol == ARB_FIXED
                                   |-> (bo_pend >> win_idx) == NUM_AC'(1))
    else $error("fixed policy winner is not the highest pending category");
  chk_clk_stop: assert property (slp_st_r == SLP_SLEEP |-> !mac_clk_en_o)
    else $error("clock running while suspended");
  chk_wake_seq: assert property (slp_st_r == SLP_SLEEP && slp_cnt_r == '0
                                 |=> wake_o ##1 mac_clk_en_o && awake)
    else $error("no wake-up after sleep expiry");
  chk_tsf_adv: assert property (wake_o && !tsf_load_i |=> tsf_r == $past(tsf_r) + $past(adv))
    else $error("TSF not advanced by sleep time");
  chk_tsf_load: assert property (tsf_load_i |=> tsf_r == $past(tsf_val_i))
    else $error("TSF did not adopt timestamp");
  chk_nav_gate: assert property (nav_busy |=> med_idle_r == 8'h00 && !txop_grant_o)
    else $error("NAV did not hold the medium busy");

  cov_grant: cover property (win_vld && $countones(bo_pend) > 1);
  cov_wake:  cover property (wake_o);
  cov_tbtt:  cover property (tbtt_o);
  cov_prog:  cover property (host_done_o);
endmodule

// ### mct_top_bench.sv
// Self-checking bench of the channel-timing unit, one task per scenario.
// Assumes the package and the PHY port model are compiled first.
`timescale 1ns/1ps
module mct_top_bench;
  import mct_pkg::*;
  logic             core_clk_i = 1'b0, resetn_i = 1'b0, phy_busy_i = 1'b0;
  logic             nav_upd_i = 1'b0, nav_clr_i = 1'b0, sleep_req_i = 1'b0;
  logic             slow_clk_i = 1'b0, tsf_load_i = 1'b0, host_req_i = 1'b0;
  logic             mc_req_i = 1'b0, phy_ack_i, txop_grant_o, sifs_trig_o;
  logic             rifs_trig_o, nav_busy_o, mac_clk_en_o, wake_o, tbtt_o;
  logic             phy_req_vld_o, host_done_o, mc_done_o, tbtt_set_i = 1'b0;
  logic [1:0]       txop_ac_o, trig_o, trig_arm_i = 2'h0;
  logic [3:0]       bo_load_i = 4'h0, dly = 4'h0;
  logic [9:0]       bo_val_i = 10'h0;
  logic [15:0]      nav_dur_i = 16'h0, phy_rdata_i, prog_rdata_o;
  logic [31:0]      sleep_cnt_i = 32'h0, bcn_intvl_i = 32'h0;
  logic [63:0]      tsf_val_i = 64'h0, tsf_o, tbtt_val_i = 64'h0;
  logic [1:0][63:0] trig_time_i = '0;
  mct_cfg_t         cfg_i = {1'b0, 8'h01, 8'h02, 8'h02, 8'h01};
  mct_phy_req_t     host_req_data_i = '0, mc_req_data_i = '0, phy_req_o;
  int               failures = 0, samples_checked = 0;
  //////////////////////////////////////////
  // Unit under test beside the PHY end of its port.
  mct_top #(.SLOW_TICK_US(8'h05)) u_dut (
    .core_clk_i, .resetn_i, .cfg_i, .phy_busy_i, .bo_load_i, .bo_val_i,
    .txop_grant_o, .txop_ac_o, .sifs_trig_o, .rifs_trig_o, .nav_upd_i,
    .nav_dur_i, .nav_clr_i, .nav_busy_o, .sleep_req_i, .sleep_cnt_i,
    .slow_clk_i, .mac_clk_en_o, .wake_o, .tsf_load_i, .tsf_val_i, .tsf_o,
    .tbtt_set_i, .tbtt_val_i, .bcn_intvl_i, .tbtt_o,
    .trig_arm_i, .trig_time_i, .trig_o, .host_req_i, .host_req_data_i,
    .mc_req_i, .mc_req_data_i, .phy_req_vld_o, .phy_req_o, .phy_ack_i,
    .phy_rdata_i, .host_done_o, .mc_done_o, .prog_rdata_o);
  mct_phy_model u_phy (
    .core_clk_i, .resetn_i, .dly_i(dly), .vld_i(phy_req_vld_o),
    .req_i(phy_req_o), .ack_o(phy_ack_i), .rdata_o(phy_rdata_i));
  // Free-running 50 MHz MAC clock.
  initial
  begin
    forever #10 core_clk_i = ~core_clk_i;
  end
  //////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic logic sig(input int k);
    return k == 0 ? txop_grant_o : (k == 1 ? mc_done_o : host_done_o);
  endfunction
  // Bounded wait for a one-cycle pulse; the count tells how long it took.
  task automatic wt(input int k, output int n);
    n = 0;
    while (sig(k) !== 1'b1 && n < 1000)
    begin
      cyc(1);
      n++;
    end
    if (n >= 1000) failures++;
  endtask
  task automatic close_out();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  //////////////////////////////////////////
  // A shorter duration must not cut a longer one; clear beats update.
  task automatic t_nav();
    nav_dur_i = 16'h0003;
    nav_upd_i = 1'b1;
    cyc(1);
    nav_dur_i = 16'h0001;
    cyc(1);
    nav_upd_i = 1'b0;
    chk("nav_set", nav_busy_o, 1'b1);
    cyc(90);
    chk("nav_keep", nav_busy_o, 1'b1);
    cyc(70);
    chk("nav_end", nav_busy_o, 1'b0);
    nav_upd_i = 1'b1;
    nav_clr_i = 1'b1;
    cyc(1);
    nav_upd_i = 1'b0;
    nav_clr_i = 1'b0;
    cyc(1);
    chk("nav_clr", nav_busy_o, 1'b0);
    $display("nav test done");
  endtask
  task automatic t_bo();
    int n;
    bo_val_i = 10'h002;
    bo_load_i = 4'b1010;
    cyc(1);
    bo_load_i = 4'h0;
    wt(0, n);
    chk("ac_fixed", txop_ac_o, 2'h3);
    cyc(1);
    chk("ac_next", {txop_grant_o, txop_ac_o}, 3'b101);
    nav_dur_i = 16'h0004;
    nav_upd_i = 1'b1;
    bo_val_i = 10'h001;
    bo_load_i = 4'b0001;
    cyc(1);
    nav_upd_i = 1'b0;
    bo_load_i = 4'h0;
    wt(0, n);
    chk("bo_hold", n > 150, 1'b1);
    chk("ac_zero", txop_ac_o, 2'h0);
    cfg_i.arb_pol = 1'b1;
    bo_val_i = 10'h000;
    bo_load_i = 4'b1010;
    cyc(1);
    bo_load_i = 4'h0;
    wt(0, n);
    chk("ac_rr", txop_ac_o, 2'h1);
    cyc(1);
    chk("ac_rr_next", txop_ac_o, 2'h3);
    cfg_i.arb_pol = 1'b0;
    $display("backoff test done");
  endtask
  task automatic t_ifs();
    int s;
    int r;
    s = 0;
    r = 0;
    phy_busy_i = 1'b1;
    cyc(10);
    phy_busy_i = 1'b0;
    for (int i = 1; i < 160; i++)
    begin
      cyc(1);
      if (sifs_trig_o === 1'b1) s = i;
      if (rifs_trig_o === 1'b1) r = i;
    end
    chk("sifs_at", s > 1 && s < 56, 1'b1);
    chk("rifs_gap", r - s, 64'h32);
    $display("interframe test done");
  endtask
  task automatic t_tsf();
    logic [63:0] at [3] = '{default: 64'h0};
    tsf_val_i = 64'h0000_0100_0000_0000;
    tsf_load_i = 1'b1;
    cyc(1);
    tsf_load_i = 1'b0;
    chk("tsf_load", tsf_o, tsf_val_i);
    trig_time_i[0] = tsf_val_i + 64'h2;
    trig_time_i[1] = tsf_val_i + 64'h1;
    trig_arm_i = 2'b11;
    tbtt_val_i = tsf_val_i + 64'h1;
    bcn_intvl_i = 32'h2;
    tbtt_set_i = 1'b1;
    cyc(1);
    trig_arm_i = 2'b00;
    tbtt_set_i = 1'b0;
    for (int i = 0; i < 200; i++)
    begin
      cyc(1);
      for (int k = 0; k < 2; k++)
        if (trig_o[k] === 1'b1) at[k] = tsf_o;
      if (tbtt_o === 1'b1) at[2] = tsf_o;
    end
    chk("tbtt", at[2], tsf_val_i + 64'h3);
    chk("trig0", at[0], tsf_val_i + 64'h2);
    chk("trig1", at[1], tsf_val_i + 64'h1);
    $display("time base test done");
  endtask
  // The slow clock runs only while the unit sleeps, two rising edges.
  task automatic t_slp();
    logic [63:0] t0;
    int n;
    sleep_cnt_i = 32'h2;
    sleep_req_i = 1'b1;
    cyc(1);
    sleep_req_i = 1'b0;
    cyc(1);
    chk("clk_off", mac_clk_en_o, 1'b0);
    t0 = tsf_o;
    n = 0;
    while (wake_o !== 1'b1 && n < 40)
    begin
      slow_clk_i = n[2];
      cyc(1);
      n++;
    end
    slow_clk_i = 1'b0;
    chk("slp_len", n > 12, 1'b1);
    chk("woke", {wake_o, mac_clk_en_o}, 2'b11);
    cyc(1);
    chk("tsf_adv", tsf_o, t0 + 64'ha);
    $display("sleep test done");
  endtask
  task automatic t_phy();
    int n;
    mc_req_data_i = {1'b1, 8'h12, 16'hbeef};
    host_req_data_i = {1'b0, 8'h34, 16'h0000};
    mc_req_i = 1'b1;
    host_req_i = 1'b1;
    cyc(2);
    chk("phy_mc", {phy_req_vld_o, phy_req_o}, {1'b1, mc_req_data_i});
    wt(1, n);
    mc_req_i = 1'b0;
    dly = 4'h6;
    chk("mc_rd", prog_rdata_o, 16'ha512);
    wt(2, n);
    host_req_i = 1'b0;
    chk("host_rd", prog_rdata_o, 16'ha534);
    $display("phy port test done");
  endtask
  //////////////////////////////////////////
  // Whole run is near 1100 cycles; the watchdog allows far more.
  initial
  begin
    repeat (20000) @(posedge core_clk_i);
    failures++;
    close_out();
  end
  initial
  begin
    repeat (6) @(posedge core_clk_i);
    #1 resetn_i = 1'b1;
    cyc(2);
    t_nav();
    t_bo();
    t_ifs();
    t_tsf();
    t_slp();
    t_phy();
    close_out();
  end
endmodule
